// >>> include/tst_defines.svh
// register offsets, field positions, reset values, coarse current steps and reading width for the sensor trim block
// assumes: included by bare name from design and testbench files
`ifndef TST_DEFINES_SVH
`define TST_DEFINES_SVH

// register offsets (byte addresses on the plain register port)
`define TST_ADDR_S1_TRIM_HIGH 16'hfe7c
`define TST_ADDR_S1_TRIM_LOW  16'hfe7d
`define TST_ADDR_S2_TRIM_HIGH 16'hfe7e
`define TST_ADDR_S2_TRIM_LOW  16'hfe7f
`define TST_ADDR_S1_CURRENT   16'hfe80
`define TST_ADDR_S2_CURRENT   16'hfe81

// field positions
`define TST_POLARITY_BIT  1
`define TST_TRIM_MSB_BIT  0
`define TST_COARSE_HI     7
`define TST_COARSE_LO     6
`define TST_FINE_HI       5
`define TST_FINE_LO       0

// reset values: trims zero, coarse field at lowest step
`define TST_RESET_TRIM    8'h00
`define TST_RESET_CURRENT 8'h00

// coarse current steps in microamps
`define TST_COARSE_STEP0  8'h0a
`define TST_COARSE_STEP1  8'h14
`define TST_COARSE_STEP2  8'h1e
`define TST_COARSE_STEP3  8'h28

// converter reading width
`define TST_READING_W     12

`endif

// >>> include/tst_pkg.sv
// types shared by the sensor trim block
// assumes: compiled before interface and design files
package tst_pkg;

	// index of a sensing input
	typedef enum logic {
		TST_INPUT_FIRST,
		TST_INPUT_SECOND
	} tst_input_e;

	// decoded trim of one input
	typedef struct packed {
		logic       negative;
		logic [8:0] magnitude;
	} tst_trim_s;

	// decoded excitation setting of one input
	typedef struct packed {
		logic [7:0] coarse_ua;
		logic [5:0] fine_steps;
	} tst_current_s;

endpackage : tst_pkg

// >>> include/tst_chan_if.sv
// per-input carrier between the register file and the per-input datapath
// assumes: one instance per sensing input
`timescale 1ns/100ps
interface tst_chan_if;
	logic [7:0] trim_high;
	logic [7:0] trim_low;
	logic [7:0] current;

	modport regs (output trim_high, output trim_low, output current);
	modport path (input trim_high, input trim_low, input current);
endinterface : tst_chan_if

// >>> design/tst_current_decode.sv
// decodes one excitation current byte into coarse microamps and fine steps
// assumes: byte comes from a register on the same clock
`timescale 1ns/100ps
`include "tst_defines.svh"
module tst_current_decode (
	// register byte
	input  wire logic [7:0]            current_byte,
	// decoded setting
	output tst_pkg::tst_current_s      setting
);

	// coarse field picks a fixed step, fine field passes through
	always_comb begin
		case (current_byte[`TST_COARSE_HI:`TST_COARSE_LO])
			2'b00:   setting.coarse_ua = `TST_COARSE_STEP0;
			2'b01:   setting.coarse_ua = `TST_COARSE_STEP1;
			2'b10:   setting.coarse_ua = `TST_COARSE_STEP2;
			default: setting.coarse_ua = `TST_COARSE_STEP3;
		endcase
		setting.fine_steps = current_byte[`TST_FINE_HI:`TST_FINE_LO];
	end

endmodule : tst_current_decode

// >>> design/tst_trim_apply.sv
// applies one input's signed offset trim to its converter reading
// assumes: reading and trim bytes share the block clock
`timescale 1ns/100ps
`include "tst_defines.svh"
module tst_trim_apply (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	// trim and current bytes
	tst_chan_if.path                         chan,
	// converter reading
	input  wire logic [`TST_READING_W-1:0]   reading,
	input  wire logic                        reading_valid,
	// results
	output tst_pkg::tst_trim_s               trim,
	output tst_pkg::tst_current_s            setting,
	output logic      [`TST_READING_W-1:0]   trimmed,
	output logic                             trimmed_valid
);

	logic [`TST_READING_W:0] sum_wide;

	// polarity bit and nine-bit magnitude; upper bits unused
	assign trim = {chan.trim_high[`TST_POLARITY_BIT], chan.trim_high[`TST_TRIM_MSB_BIT],
		chan.trim_low};

	// plain wide add or subtract of the trim; the top bit flags overflow for the clamp
	always_comb begin
		if (trim.negative) begin
			sum_wide = {1'b0, reading} - {4'h0, trim.magnitude};
		end else begin
			sum_wide = {1'b0, reading} + {4'h0, trim.magnitude};
		end
	end

	// registered trimmed reading, clamped at both ends
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trimmed <= '0;
		end else if (reading_valid) begin
			if (sum_wide[`TST_READING_W]) begin
				trimmed <= trim.negative ? '0 : '1;
			end else begin
				trimmed <= sum_wide[`TST_READING_W-1:0];
			end
		end
	end

	// result valid one cycle after the reading
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trimmed_valid <= 1'b0;
		end else begin
			trimmed_valid <= reading_valid;
		end
	end

	// current byte decode
	tst_current_decode u_decode (
		.current_byte (chan.current),
		.setting      (setting)
	);

endmodule : tst_trim_apply

// >>> design/tst_sensor_trim.sv
// top of the temperature sensing trim and excitation configuration block
// assumes: converter readings arrive on clk; register port master on clk
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "tst_defines.svh"

// ****************************************************************
// notes
// ****************************************************************
// Notes on behaviour
// - Bit 1 of each high trim register picks the sign: 1 subtracts, 0 adds the trim.
// - The first input's trim magnitude is high bit 0 above the eight low bits, applied to its reading.
// - The second input's trim is formed the same way and applied to the second reading.
// - Coarse bits 7:6 of the first current register give 10, 20, 30 or 40 microamps.
// - The second current register uses the same coarse encoding.
// - Fine bits 5:0 are a per-step current added on top of any coarse setting.
// - After reset each coarse field selects the lowest step, 10 microamps.
module tst_sensor_trim (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       resetn,
	// register port
	input  wire logic [15:0]                reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_write,
	input  wire logic                       reg_read,
	output logic      [7:0]                 reg_rdata,
	// first_temp_sense_input converter side
	input  wire logic [`TST_READING_W-1:0]  first_reading,
	input  wire logic                       first_reading_valid,
	output logic      [`TST_READING_W-1:0]  first_trimmed,
	output logic                            first_trimmed_valid,
	output logic      [7:0]                 first_coarse_ua,
	output logic      [5:0]                 first_fine_steps,
	// second_temp_sense_input converter side
	input  wire logic [`TST_READING_W-1:0]  second_reading,
	input  wire logic                       second_reading_valid,
	output logic      [`TST_READING_W-1:0]  second_trimmed,
	output logic                            second_trimmed_valid,
	output logic      [7:0]                 second_coarse_ua,
	output logic      [5:0]                 second_fine_steps
);

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic rst_sync1_reg;
	logic rst_n;

	// two-stage release of the asynchronous reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync1_reg <= 1'b0;
			rst_n         <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_n         <= rst_sync1_reg;
		end
	end

	// ****************************************************************
	// register file
	// ****************************************************************
	logic [7:0] s1_trim_high_reg;
	logic [7:0] s1_trim_low_reg;
	logic [7:0] s2_trim_high_reg;
	logic [7:0] s2_trim_low_reg;
	logic [7:0] s1_current_reg;
	logic [7:0] s2_current_reg;
	logic [7:0] rdata_next;

	// byte writes, all bits stored
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_trim_high_reg <= `TST_RESET_TRIM;
			s1_trim_low_reg  <= `TST_RESET_TRIM;
			s2_trim_high_reg <= `TST_RESET_TRIM;
			s2_trim_low_reg  <= `TST_RESET_TRIM;
			s1_current_reg   <= `TST_RESET_CURRENT;
			s2_current_reg   <= `TST_RESET_CURRENT;
		end else if (reg_write) begin
			case (reg_addr)
				`TST_ADDR_S1_TRIM_HIGH: s1_trim_high_reg <= reg_wdata;
				`TST_ADDR_S1_TRIM_LOW:  s1_trim_low_reg  <= reg_wdata;
				`TST_ADDR_S2_TRIM_HIGH: s2_trim_high_reg <= reg_wdata;
				`TST_ADDR_S2_TRIM_LOW:  s2_trim_low_reg  <= reg_wdata;
				`TST_ADDR_S1_CURRENT:   s1_current_reg   <= reg_wdata;
				`TST_ADDR_S2_CURRENT:   s2_current_reg   <= reg_wdata;
				default:                ;
			endcase
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		case (reg_addr)
			`TST_ADDR_S1_TRIM_HIGH: rdata_next = s1_trim_high_reg;
			`TST_ADDR_S1_TRIM_LOW:  rdata_next = s1_trim_low_reg;
			`TST_ADDR_S2_TRIM_HIGH: rdata_next = s2_trim_high_reg;
			`TST_ADDR_S2_TRIM_LOW:  rdata_next = s2_trim_low_reg;
			`TST_ADDR_S1_CURRENT:   rdata_next = s1_current_reg;
			`TST_ADDR_S2_CURRENT:   rdata_next = s2_current_reg;
			default:                rdata_next = 8'h00;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ****************************************************************
	// per-input datapaths
	// ****************************************************************
	tst_chan_if chan_first ();
	tst_chan_if chan_second ();
	tst_pkg::tst_current_s first_setting;
	tst_pkg::tst_current_s second_setting;

	// register bytes onto the carriers
	assign chan_first.trim_high  = s1_trim_high_reg;
	assign chan_first.trim_low   = s1_trim_low_reg;
	assign chan_first.current    = s1_current_reg;
	assign chan_second.trim_high = s2_trim_high_reg;
	assign chan_second.trim_low  = s2_trim_low_reg;
	assign chan_second.current   = s2_current_reg;

	// first input trim and excitation
	tst_trim_apply u_first (
		.clk           (clk),
		.rst_n         (rst_n),
		.chan          (chan_first.path),
		.reading       (first_reading),
		.reading_valid (first_reading_valid),
		.trim          (),
		.setting       (first_setting),
		.trimmed       (first_trimmed),
		.trimmed_valid (first_trimmed_valid)
	);

	// second input trim and excitation
	tst_trim_apply u_second (
		.clk           (clk),
		.rst_n         (rst_n),
		.chan          (chan_second.path),
		.reading       (second_reading),
		.reading_valid (second_reading_valid),
		.trim          (),
		.setting       (second_setting),
		.trimmed       (second_trimmed),
		.trimmed_valid (second_trimmed_valid)
	);

	// excitation codes to the analog source, straight from registers
	assign first_coarse_ua   = first_setting.coarse_ua;
	assign first_fine_steps  = first_setting.fine_steps;
	assign second_coarse_ua  = second_setting.coarse_ua;
	assign second_fine_steps = second_setting.fine_steps;

	// ****************************************************************
	// checks
	// ****************************************************************
	property p_first_sign;
		@(posedge clk) disable iff (!rst_n)
		(first_reading_valid && s1_trim_high_reg[1] && first_reading > 12'h1ff)
		|=> first_trimmed == $past(first_reading) - {3'h0, $past(s1_trim_high_reg[0]),
			$past(s1_trim_low_reg)};
	endproperty
	a_first_sign: assert property (p_first_sign) else $error("negative trim wrong");

	property p_first_add;
		@(posedge clk) disable iff (!rst_n)
		(first_reading_valid && !s1_trim_high_reg[1] && first_reading < 12'he00)
		|=> first_trimmed == $past(first_reading) + {3'h0, $past(s1_trim_high_reg[0]),
			$past(s1_trim_low_reg)};
	endproperty
	a_first_add: assert property (p_first_add) else $error("first trim wrong");

	property p_second_add;
		@(posedge clk) disable iff (!rst_n)
		(second_reading_valid && !s2_trim_high_reg[1] && second_reading < 12'he00)
		|=> second_trimmed == $past(second_reading) + {3'h0, $past(s2_trim_high_reg[0]),
			$past(s2_trim_low_reg)};
	endproperty
	a_second_add: assert property (p_second_add) else $error("second trim wrong");

	property p_first_coarse;
		@(posedge clk) disable iff (!rst_n)
		first_coarse_ua == 8'h0a + 8'h0a * {6'h00, s1_current_reg[7:6]};
	endproperty
	a_first_coarse: assert property (p_first_coarse) else $error("first coarse wrong");

	property p_second_coarse;
		@(posedge clk) disable iff (!rst_n)
		second_coarse_ua == 8'h0a + 8'h0a * {6'h00, s2_current_reg[7:6]};
	endproperty
	a_second_coarse: assert property (p_second_coarse) else $error("second coarse wrong");

	property p_fine;
		@(posedge clk) disable iff (!rst_n)
		(reg_write && reg_addr == 16'hfe80) |=> first_fine_steps == $past(reg_wdata[5:0]);
	endproperty
	a_fine: assert property (p_fine) else $error("fine step not taken");

	property p_reset_coarse;
		@(posedge clk) $rose(rst_n) |-> first_coarse_ua == 8'h0a && second_coarse_ua == 8'h0a;
	endproperty
	a_reset_coarse: assert property (p_reset_coarse) else $error("coarse not lowest");

	property p_readback;
		@(posedge clk) disable iff (!rst_n)
		(reg_write && reg_addr == 16'hfe7e) ##1 (reg_read && reg_addr == 16'hfe7e && !reg_write)
		|=> reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch");

	property p_second_sign;
		@(posedge clk) disable iff (!rst_n)
		(second_reading_valid && s2_trim_high_reg[1] && second_reading > 12'h1ff)
		|=> second_trimmed == $past(second_reading) - {3'h0, $past(s2_trim_high_reg[0]),
			$past(s2_trim_low_reg)};
	endproperty
	a_second_sign: assert property (p_second_sign) else $error("second sign wrong");

	property p_first_floor;
		@(posedge clk) disable iff (!rst_n)
		(first_reading_valid && s1_trim_high_reg[1]
			&& {3'h0, s1_trim_high_reg[0], s1_trim_low_reg} > first_reading)
		|=> first_trimmed == 12'h000;
	endproperty
	a_first_floor: assert property (p_first_floor) else $error("first floor wrong");

	property p_second_floor;
		@(posedge clk) disable iff (!rst_n)
		(second_reading_valid && s2_trim_high_reg[1]
			&& {3'h0, s2_trim_high_reg[0], s2_trim_low_reg} > second_reading)
		|=> second_trimmed == 12'h000;
	endproperty
	a_second_floor: assert property (p_second_floor) else $error("second floor wrong");

	property p_first_ceiling;
		@(posedge clk) disable iff (!rst_n)
		(first_reading_valid && !s1_trim_high_reg[1]
			&& ({1'b0, first_reading} + {4'h0, s1_trim_high_reg[0], s1_trim_low_reg}) > 13'h0fff)
		|=> first_trimmed == 12'hfff;
	endproperty
	a_first_ceiling: assert property (p_first_ceiling) else $error("first ceiling wrong");

	property p_second_ceiling;
		@(posedge clk) disable iff (!rst_n)
		(second_reading_valid && !s2_trim_high_reg[1]
			&& ({1'b0, second_reading} + {4'h0, s2_trim_high_reg[0], s2_trim_low_reg}) > 13'h0fff)
		|=> second_trimmed == 12'hfff;
	endproperty
	a_second_ceiling: assert property (p_second_ceiling) else $error("second ceiling wrong");

	property p_first_hold;
		@(posedge clk) disable iff (!rst_n)
		!first_reading_valid |=> $stable(first_trimmed);
	endproperty
	a_first_hold: assert property (p_first_hold) else $error("first result moved");

	property p_second_hold;
		@(posedge clk) disable iff (!rst_n)
		!second_reading_valid |=> $stable(second_trimmed);
	endproperty
	a_second_hold: assert property (p_second_hold) else $error("second result moved");

	property p_result_valid;
		@(posedge clk) disable iff (!rst_n)
		first_trimmed_valid == $past(first_reading_valid)
			&& second_trimmed_valid == $past(second_reading_valid);
	endproperty
	a_result_valid: assert property (p_result_valid) else $error("result valid wrong");

	property p_rdata_idle;
		@(posedge clk) disable iff (!rst_n)
		!$past(reg_read) |-> reg_rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	property p_unmapped_read;
		@(posedge clk) disable iff (!rst_n)
		(reg_read && (reg_addr < 16'hfe7c || reg_addr > 16'hfe81)) |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	property p_second_fine;
		@(posedge clk) disable iff (!rst_n)
		(reg_write && reg_addr == 16'hfe81) |=> second_fine_steps == $past(reg_wdata[5:0]);
	endproperty
	a_second_fine: assert property (p_second_fine) else $error("second fine not taken");

	property p_reset_result;
		@(posedge clk) $rose(rst_n) |-> first_trimmed == 12'h000 && second_trimmed == 12'h000
			&& !first_trimmed_valid && !second_trimmed_valid;
	endproperty
	a_reset_result: assert property (p_reset_result) else $error("result not cleared");

	property p_write_lands;
		@(posedge clk) disable iff (!rst_n)
		(reg_write && reg_addr == 16'hfe7d) |=> s1_trim_low_reg == $past(reg_wdata);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write not stored");

endmodule : tst_sensor_trim

// >>> testbench/tst_conv_model.sv
// behavioural model of one sensing resistor and its converter
// assumes: bench pulses go for one cycle with value; answers after one or three cycles
`timescale 1ns/100ps
module tst_conv_model (
	// clock
	input  wire logic        clk,
	// request from the bench
	input  wire logic        go,
	input  wire logic [11:0] value,
	input  wire logic        slow,
	// converter side
	output logic      [11:0] reading,
	output logic             reading_valid
);
	logic [11:0] held_reg;
	logic [2:0]  wait_reg;

	// start idle so no reading is offered before the first request
	initial begin
		reading       = 12'h000;
		reading_valid = 1'b0;
		held_reg      = 12'h000;
		wait_reg      = 3'h0;
	end

	// reading toggles between samples so a stale value never looks valid
	always @(posedge clk) begin
		if (go) begin
			held_reg <= value;
			wait_reg <= slow ? 3'h3 : 3'h1;
		end else if (wait_reg != 3'h0) begin
			wait_reg <= wait_reg - 3'h1;
		end
		if (!go && wait_reg == 3'h1) begin
			reading       <= held_reg;
			reading_valid <= 1'b1;
		end else begin
			reading       <= ~reading;
			reading_valid <= 1'b0;
		end
	end
endmodule : tst_conv_model

// >>> testbench/testbench.sv
// self-checking bench for the sensor trim block
// assumes: package, interface and design compiled first; one 50 MHz clock
`timescale 1ns/100ps
`include "tst_defines.svh"
module testbench;
	// ****************************************************************
	// signals
	// ****************************************************************
	typedef struct packed {
		logic        ch;
		logic [7:0]  hi;
		logic [7:0]  lo;
		logic [7:0]  cur;
		logic [11:0] rd;
		logic [11:0] exp;
		logic [7:0]  ua;
	} tst_row_s;
	logic        clk, resetn, reg_write, reg_read;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, cua0, cua1;
	logic [1:0]  go, slow;
	logic [11:0] value, rdg0, rdg1, trm0, trm1;
	logic        rv0, rv1, tv0, tv1;
	logic [5:0]  fs0, fs1;
	int          err_count, n_compared, cycles;
	tst_row_s    r;
	logic [15:0] ha, la, ca;
	tst_row_s    rows [10] = '{
		'{1'b0, 8'h00, 8'h05, 8'h00, 12'h064, 12'h069, 8'h0a},
		'{1'b0, 8'h02, 8'h05, 8'h41, 12'h064, 12'h05f, 8'h14},
		'{1'b0, 8'h01, 8'h00, 8'hbf, 12'h010, 12'h110, 8'h1e},
		'{1'b0, 8'h03, 8'hff, 8'hc0, 12'h300, 12'h101, 8'h28},
		'{1'b1, 8'hfc, 8'h10, 8'h2a, 12'h020, 12'h030, 8'h0a},
		'{1'b1, 8'h02, 8'h30, 8'h55, 12'h020, 12'h000, 8'h14},
		'{1'b1, 8'h01, 8'hff, 8'haa, 12'hf00, 12'hfff, 8'h1e},
		'{1'b1, 8'h02, 8'h01, 8'hff, 12'h202, 12'h201, 8'h28},
		'{1'b0, 8'h02, 8'h80, 8'h00, 12'h040, 12'h000, 8'h0a},
		'{1'b0, 8'h01, 8'h01, 8'h7f, 12'hf80, 12'hfff, 8'h14}};

	// ****************************************************************
	// design and converter models
	// ****************************************************************
	tst_sensor_trim u_tst_sensor_trim (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .first_reading(rdg0), .first_reading_valid(rv0),
		.first_trimmed(trm0), .first_trimmed_valid(tv0), .first_coarse_ua(cua0),
		.first_fine_steps(fs0), .second_reading(rdg1), .second_reading_valid(rv1),
		.second_trimmed(trm1), .second_trimmed_valid(tv1), .second_coarse_ua(cua1),
		.second_fine_steps(fs1));
	tst_conv_model u_tst_conv_model_0 (.clk(clk), .go(go[0]), .value(value),
		.slow(slow[0]), .reading(rdg0), .reading_valid(rv0));
	tst_conv_model u_tst_conv_model_1 (.clk(clk), .go(go[1]), .value(value),
		.slow(slow[1]), .reading(rdg1), .reading_valid(rv1));

	// clock and hang guard
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_count++;
			stop_test();
		end
	end

	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		cmp({8'h00, reg_rdata}, {8'h00, exp});
	endtask : rd

	// write then read the same place with no gap between the strobes
	task automatic wr_rd(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_write <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
		reg_read  <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		cmp({8'h00, reg_rdata}, {8'h00, d});
	endtask : wr_rd

	// one converter sample, then wait a bounded time for the trimmed result
	task automatic sample(input logic ch, input logic [11:0] v, input logic sl,
			input logic [11:0] exp);
		int n;
		@(posedge clk);
		go[ch]   <= 1'b1;
		slow[ch] <= sl;
		value    <= v;
		@(posedge clk);
		go[ch] <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while ((ch ? tv1 : tv0) !== 1'b1 && n < 8);
		cmp({15'h0000, ch ? tv1 : tv0}, 16'h0001);
		cmp({4'h0, ch ? trm1 : trm0}, {4'h0, exp});
	endtask : sample

	task automatic check_reset();
		rd(`TST_ADDR_S1_TRIM_HIGH, 8'h00);
		rd(`TST_ADDR_S1_TRIM_LOW, 8'h00);
		rd(`TST_ADDR_S2_TRIM_HIGH, 8'h00);
		rd(`TST_ADDR_S2_TRIM_LOW, 8'h00);
		rd(`TST_ADDR_S1_CURRENT, 8'h00);
		rd(`TST_ADDR_S2_CURRENT, 8'h00);
		cmp({8'h00, cua0}, 16'h000a);
		cmp({8'h00, cua1}, 16'h000a);
		cmp({10'h000, fs0}, 16'h0000);
		cmp({10'h000, fs1}, 16'h0000);
		cmp({4'h0, trm0}, 16'h0000);
		cmp({4'h0, trm1}, 16'h0000);
		cmp({14'h0000, tv1, tv0}, 16'h0000);
	endtask : check_reset

	task automatic stop_test();
		$display("TB: compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		go = 2'b00;
		slow = 2'b00;
		value = 12'h000;
		err_count = 0;
		n_compared = 0;
		cycles = 0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		check_reset();
		$display("TB: test reset values done");
		// table rows: program one input, read back, convert, check the decode
		foreach (rows[i]) begin
			r = rows[i];
			ha = r.ch ? `TST_ADDR_S2_TRIM_HIGH : `TST_ADDR_S1_TRIM_HIGH;
			la = r.ch ? `TST_ADDR_S2_TRIM_LOW : `TST_ADDR_S1_TRIM_LOW;
			ca = r.ch ? `TST_ADDR_S2_CURRENT : `TST_ADDR_S1_CURRENT;
			wr(ha, r.hi);
			wr(la, r.lo);
			wr(ca, r.cur);
			rd(ha, r.hi);
			rd(la, r.lo);
			rd(ca, r.cur);
			sample(r.ch, r.rd, i[0], r.exp);
			cmp({8'h00, r.ch ? cua1 : cua0}, {8'h00, r.ua});
			cmp({10'h000, r.ch ? fs1 : fs0}, {10'h000, r.cur[5:0]});
		end
		$display("TB: test table rows done");
		// unmapped place: write ignored, read gives zero, neighbours untouched
		wr(16'hfe82, 8'h5a);
		rd(16'hfe82, 8'h00);
		rd(16'hfe7b, 8'h00);
		rd(`TST_ADDR_S2_CURRENT, 8'hff);
		wr_rd(`TST_ADDR_S2_TRIM_HIGH, 8'hc2);
		$display("TB: test unmapped access done");
		// second reset in mid-run brings every setting back
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		check_reset();
		$display("TB: test second reset done");
		stop_test();
	end
endmodule : testbench
